// >>> common/psc_pkg.sv
// Package for the pseudo static memory host controller.
// Assumes a 100 MHz system clock and an external 1M x 16 memory on plain pins.
package psc_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Settling times in their own units
  localparam int unsigned SETTLE_US = 300;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Access timing: cycle time 70 ns, strobe 70 ns, read data wait 70 ns
  localparam int unsigned CYCLE_NS = 70;
  localparam int unsigned CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEEP_LOW_NS = 30;
  localparam int unsigned DEEP_LOW_CYC = (DEEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = 1;

  typedef enum logic [1:0] {
    PSC_CMD_READ  = 2'h0,
    PSC_CMD_WRITE = 2'h1,
    PSC_CMD_SLEEP = 2'h2,
    PSC_CMD_WAKE  = 2'h3
  } psc_cmd_t;

  typedef struct packed {
    psc_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] byte_en;
  } psc_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic sleep_request_n;
    logic write_n;
    logic out_en_n;
    logic low_byte_sel_n;
    logic high_byte_sel_n;
  } psc_ctl_t;

  localparam psc_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// >>> rtl/psc_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin inputs.
// Assumes the pins are stable within a clock period or may be sampled loosely.
module psc_sync #(
  parameter int unsigned W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// >>> rtl/psc_host.sv
// Host controller driving a 1M x 16 pseudo static memory over its pins.
// Assumes one 100 MHz clock; data pins are split into in, out and enable.
module psc_host
  import psc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire psc_pkg::psc_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [psc_pkg::DATA_W-1:0] rsp_rdata_o,
  output logic asleep_o,
  output logic contents_lost_o,
  output logic [psc_pkg::ADDR_W-1:0] word_addr_o,
  output psc_pkg::psc_ctl_t ctl_o,
  input wire logic [psc_pkg::DATA_W-1:0] data_pins_i,
  output logic [psc_pkg::DATA_W-1:0] data_pins_o,
  output logic [psc_pkg::DATA_W-1:0] data_pins_oe_o
);
  import psc_pkg::*;

  typedef enum logic [2:0] {
    PSC_ST_SETTLE = 3'h0,
    PSC_ST_IDLE   = 3'h1,
    PSC_ST_SETUP  = 3'h2,
    PSC_ST_STROBE = 3'h3,
    PSC_ST_HOLD   = 3'h4,
    PSC_ST_DEEP   = 3'h5,
    PSC_ST_WAKE   = 3'h6
  } psc_state_t;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Sized from the parameter so a longer settle time cannot wrap the counter
  localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + CYCLE_CYC) + 1;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(CYCLE_CYC - 1);
  localparam logic [CNT_W-1:0] DEEP_LAST = CNT_W'(DEEP_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

  psc_state_t state_r;
  psc_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic cnt_done;
  logic [DATA_W-1:0] rd_sync;
  psc_req_t req_r;
  psc_req_t req_nxt;
  logic is_write;
  logic take;

  // Read data pass two flops since the memory answers without a clock
  psc_sync #(
    .W(DATA_W)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(data_pins_i),
    .sync_o(rd_sync)
  );

  assign is_write = (req_r.cmd == PSC_CMD_WRITE);
  assign take = (state_r == PSC_ST_IDLE) && req_valid_i && req_ready_o;
  // Data lanes follow the request being taken, not the one before it
  assign req_nxt = take ? req_i : req_r;

  always_comb begin
    cnt_done = 1'b0;
    case (state_r)
      PSC_ST_SETTLE: cnt_done = (cnt_r == SETTLE_LAST);
      PSC_ST_WAKE: cnt_done = (cnt_r == SETTLE_LAST);
      PSC_ST_STROBE: cnt_done = (cnt_r == STROBE_LAST);
      PSC_ST_DEEP: cnt_done = (cnt_r >= DEEP_LAST);
      default: cnt_done = 1'b1;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PSC_ST_SETTLE: begin
        if (cnt_done) begin
          state_nxt = PSC_ST_IDLE;
        end
      end
      PSC_ST_IDLE: begin
        if (take) begin
          case (req_i.cmd)
            PSC_CMD_SLEEP: state_nxt = PSC_ST_DEEP;
            PSC_CMD_WAKE: state_nxt = PSC_ST_IDLE;
            default: state_nxt = PSC_ST_SETUP;
          endcase
        end
      end
      PSC_ST_SETUP: state_nxt = PSC_ST_STROBE;
      PSC_ST_STROBE: begin
        if (cnt_done) begin
          state_nxt = PSC_ST_HOLD;
        end
      end
      PSC_ST_HOLD: state_nxt = PSC_ST_IDLE;
      PSC_ST_DEEP: begin
        // Only a wake request leaves sleep; other requests wait in the source
        if (cnt_done && req_valid_i && req_i.cmd == PSC_CMD_WAKE) begin
          state_nxt = PSC_ST_WAKE;
        end
      end
      PSC_ST_WAKE: begin
        if (cnt_done) begin
          state_nxt = PSC_ST_IDLE;
        end
      end
      default: state_nxt = PSC_ST_SETTLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= PSC_ST_SETTLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (!cnt_done) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Request is held so address stays fixed for the whole access
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_r <= '0;
    end else if (take) begin
      req_r <= req_i;
    end
  end

  // Ready only in idle; a wake in sleep ends sleep without it and is taken once back in idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state_nxt == PSC_ST_IDLE) && !take;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_addr_o <= '0;
    end else if (take) begin
      word_addr_o <= req_i.addr;
    end
  end

  // All controls idle high: a valid level at every pin, never floating
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_o <= CTL_IDLE;
    end else begin
      ctl_o <= CTL_IDLE;
      case (state_nxt)
        PSC_ST_STROBE: begin
          ctl_o.chip_sel_n <= 1'b0;
          ctl_o.write_n <= !is_write;
          ctl_o.out_en_n <= is_write;
          ctl_o.low_byte_sel_n <= !req_r.byte_en[0];
          ctl_o.high_byte_sel_n <= !req_r.byte_en[1];
        end
        PSC_ST_DEEP: begin
          ctl_o.sleep_request_n <= 1'b0;
          ctl_o.chip_sel_n <= 1'b1;
        end
        default: ctl_o <= CTL_IDLE;
      endcase
    end
  end

  // Host drives data only during writes; reads leave the lanes released
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_pins_o <= '0;
      data_pins_oe_o <= '0;
    end else begin
      data_pins_o <= req_nxt.wdata;
      if ((req_nxt.cmd == PSC_CMD_WRITE) && (state_nxt == PSC_ST_SETUP
          || state_nxt == PSC_ST_STROBE || state_nxt == PSC_ST_HOLD)) begin
        data_pins_oe_o <= lane_mask(req_nxt.byte_en);
      end else begin
        data_pins_oe_o <= '0;
      end
    end
  end

  // Sampled at strobe end; unselected lanes read as zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= (state_r == PSC_ST_HOLD) && !is_write;
      if (state_r == PSC_ST_HOLD && !is_write) begin
        rsp_rdata_o <= rd_sync & lane_mask(req_r.byte_en);
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      asleep_o <= 1'b0;
      contents_lost_o <= 1'b0;
    end else begin
      asleep_o <= (state_nxt == PSC_ST_DEEP) || (state_nxt == PSC_ST_WAKE);
      if (state_nxt == PSC_ST_DEEP) begin
        contents_lost_o <= 1'b1;
      end else if (take && req_i.cmd == PSC_CMD_WRITE) begin
        contents_lost_o <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/psc_host_assertions.sv
// Checker for the memory host controller pins.
// Assumes binding into psc_host; sees its ports only.
module psc_host_assertions
  import psc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rsp_valid_o,
  input wire logic [psc_pkg::ADDR_W-1:0] word_addr_o,
  input wire psc_pkg::psc_ctl_t ctl_o,
  input wire logic [psc_pkg::DATA_W-1:0] data_pins_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int unsigned cnt_r;
  // Restarts on wake, so one count covers power-up and wake settling
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      cnt_r <= 0;
    else if ($rose(ctl_o.sleep_request_n))
      cnt_r <= 0;
    else if (cnt_r < SETTLE_CYCLES)
      cnt_r <= cnt_r + 1;
  end
  a_settle_wait: assert property (
    $fell(ctl_o.chip_sel_n) |-> cnt_r >= SETTLE_CYCLES) else $error("access too early");
  a_addr_hold: assert property (
    !ctl_o.chip_sel_n |-> $stable(word_addr_o)) else $error("address moved");
  a_strobe_len: assert property (
    $fell(ctl_o.chip_sel_n) |-> !ctl_o.chip_sel_n [*7] ##1 ctl_o.chip_sel_n)
    else $error("strobe length");
  a_sleep_desel: assert property (
    !ctl_o.sleep_request_n |-> ctl_o.chip_sel_n) else $error("select in sleep");
  a_wake_desel: assert property (
    $rose(ctl_o.sleep_request_n) |-> ctl_o.chip_sel_n [*8]) else $error("select at wake");
  a_read_float: assert property (
    !ctl_o.out_en_n |-> ctl_o.write_n && data_pins_oe_o == '0) else $error("bus clash");
  a_write_lanes: assert property (
    !ctl_o.write_n |-> data_pins_oe_o ==
      {{8{!ctl_o.high_byte_sel_n}}, {8{!ctl_o.low_byte_sel_n}}}) else $error("lane drive");
  a_read_rsp: assert property (
    $fell(ctl_o.out_en_n) |-> ##8 rsp_valid_o) else $error("read answer late");
endmodule
bind psc_host psc_host_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .rsp_valid_o(rsp_valid_o),
  .word_addr_o(word_addr_o), .ctl_o(ctl_o), .data_pins_oe_o(data_pins_oe_o));

// >>> testbench/psc_mem_model.sv
// Behavioural model of the 1M x 16 memory on the host pins.
// Assumes the bench resolves the shared data lines and feeds them back.
module psc_mem_model
  import psc_pkg::*;
(
  input wire logic [psc_pkg::ADDR_W-1:0] addr_i,
  input wire psc_pkg::psc_ctl_t ctl_i,
  input wire logic [psc_pkg::DATA_W-1:0] data_i,
  output logic [psc_pkg::DATA_W-1:0] data_o,
  output logic [psc_pkg::DATA_W-1:0] oe_o
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] lane;
  logic sel;
  assign sel = !ctl_i.chip_sel_n && ctl_i.sleep_request_n;
  assign lane = {{8{sel && !ctl_i.high_byte_sel_n}}, {8{sel && !ctl_i.low_byte_sel_n}}};
  assign oe_o = (ctl_i.write_n && !ctl_i.out_en_n) ? lane : '0;
  // Level-sensitive write; unwritten and lost words read as zero
  always @(addr_i or ctl_i or data_i) begin
    if (!ctl_i.sleep_request_n)
      mem.delete();
    else if (!ctl_i.write_n && lane != '0)
      mem[addr_i] = (data_o & ~lane) | (data_i & lane);
    data_o = mem.exists(addr_i) ? mem[addr_i] : '0;
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the memory host controller.
// Assumes the memory model and the checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, req_valid_i = 0, req_ready_o, rsp_valid_o, asleep_o, lost;
  psc_req_t req_i = '0;
  psc_ctl_t ctl_o;
  logic [ADDR_W-1:0] word_addr_o;
  logic [DATA_W-1:0] rdata, dq_o, dq_oe, m_d, m_oe, dq_i, flt = 16'h5a5a;
  logic [DATA_W-1:0] sh [int];
  int error_cnt = 0, samples_checked = 0, seed = 32'h7461;
  `define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
  always #5 sys_clk_i = ~sys_clk_i;
  // Released lines keep changing so a stale value cannot match
  always @(posedge sys_clk_i) flt <= ~flt;
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & m_oe & m_d) | (~dq_oe & ~m_oe & flt);
  psc_host #(.SETTLE_CYCLES(20)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rdata), .asleep_o(asleep_o),
    .contents_lost_o(lost), .word_addr_o(word_addr_o), .ctl_o(ctl_o),
    .data_pins_i(dq_i), .data_pins_o(dq_o), .data_pins_oe_o(dq_oe));
  psc_mem_model u_mem (.addr_i(word_addr_o), .ctl_i(ctl_o), .data_i(dq_i), .data_o(m_d),
    .oe_o(m_oe));
  function automatic logic [DATA_W-1:0] lanes(input logic [1:0] b);
    return {{8{b[1]}}, {8{b[0]}}};
  endfunction
  task automatic req(input psc_cmd_t c, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [1:0] b);
    req_i = '{c, a, d, b};
    req_valid_i = 1;
    while (req_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    req_valid_i = 0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [1:0] b);
    logic [DATA_W-1:0] v;
    v = sh.exists(a) ? sh[a] : '0;
    sh[a] = (v & ~lanes(b)) | (d & lanes(b));
    req(PSC_CMD_WRITE, a, d, b);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] b);
    logic [DATA_W-1:0] v;
    v = sh.exists(a) ? sh[a] : '0;
    req(PSC_CMD_READ, a, 16'h0, b);
    while (rsp_valid_o !== 1'b1) @(negedge sys_clk_i);
    `CHK("rdata", v & lanes(b), rdata)
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // About 600 cycles are needed; this leaves wide margin
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
  initial begin
    logic [ADDR_W-1:0] a;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 0;
    `CHK("ctl reset", CTL_IDLE, ctl_o)
    `CHK("ready reset", 1'b0, req_ready_o)
    `CHK("oe reset", 16'h0, dq_oe)
    for (int i = 0; i < 26; i++) begin
      // Corner words first, then a narrow range so lanes get merged
      a = (i < 2) ? {ADDR_W{i[0]}} : ADDR_W'($random(seed) & 7);
      wr(a, DATA_W'($random(seed)), (i < 2) ? 2'h3 : 2'($random(seed)));
      rd(a, 2'($random(seed)));
    end
    rd(20'hfffff, 2'h3);
    req(PSC_CMD_SLEEP, 20'h0, 16'h0, 2'h0);
    @(negedge sys_clk_i);
    `CHK("asleep", 1'b1, asleep_o)
    `CHK("sleep pin", 1'b0, ctl_o.sleep_request_n)
    `CHK("lost", 1'b1, lost)
    sh.delete();
    req(PSC_CMD_WAKE, 20'h0, 16'h0, 2'h0);
    `CHK("awake", 1'b0, asleep_o)
    wr(20'h00003, 16'hbeef, 2'h3);
    `CHK("lost", 1'b0, lost)
    rd(20'h00003, 2'h3);
    rd(20'h00001, 2'h3);
    end_sim;
  end
endmodule
